// [rtl/smms_pkg.sv]
/*
 * package for the safety mode supervisor: register map, field positions,
 * reset values, press timing and operating-mode encoding.
 * assumes a 100 MHz clock and an apb slave with 32-bit data.
 */
package smms_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int SHORT_PRESS_MS = 3000;
    localparam int LONG_PRESS_MS = 15000;
    localparam int DEBOUNCE_US = 10000;
    localparam int SHORT_PRESS_CYC_DEF = SHORT_PRESS_MS * (CLK_HZ / 1000);
    localparam int LONG_PRESS_CYC_DEF = LONG_PRESS_MS * (CLK_HZ / 1000);
    localparam int DEBOUNCE_CYC_DEF = DEBOUNCE_US * (CLK_HZ / 1_000_000);
    localparam int RESTART_SAFE_CYC = 16;
    localparam int CNT_W = 32;

    localparam int NUM_IN = 20;
    localparam int NUM_OUT = 4;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_ERR = 8'h08;
    localparam logic [7:0] ADDR_ERR_CAUSE = 8'h0C;
    localparam logic [7:0] ADDR_OUT_REQ = 8'h10;

    // ctrl fields
    localparam int CTRL_DL_START = 0;
    localparam int CTRL_DL_DONE = 1;
    localparam int CTRL_ERR_LONG = 2;
    localparam int CTRL_RUN_EN = 3;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // status fields
    localparam int ST_MODE_LSB = 0;
    localparam int ST_STICK = 3;
    localparam int ST_USB = 4;
    localparam int ST_PENDING = 5;
    localparam int ST_DL_REFUSED = 6;
    localparam int ST_STORE_REQ = 7;
    localparam int ST_SWAP = 8;
    localparam int ST_RESTARTS_LSB = 16;

    localparam logic [7:0] ERR_RESET = 8'h00;
    localparam logic [3:0] OUT_REQ_RESET = 4'h0;

    typedef enum logic [2:0] {
        SMMS_INIT = 3'b000,
        SMMS_RUN = 3'b001,
        SMMS_STD = 3'b011,
        SMMS_HALT = 3'b010,
        SMMS_SWAP = 3'b110,
        SMMS_SAFE = 3'b111
    } smms_mode_t;
endpackage

// [rtl/smms_button.sv]
/*
 * acknowledge button conditioner: debounce, then measure the hold time.
 * assumes button_n is synchronous to clk and low while pressed.
 */
module smms_button #(
    parameter int DEBOUNCE_CYC = smms_pkg::DEBOUNCE_CYC_DEF,
    parameter int SHORT_CYC = smms_pkg::SHORT_PRESS_CYC_DEF,
    parameter int LONG_CYC = smms_pkg::LONG_PRESS_CYC_DEF
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // raw button
    input wire logic button_n,
    // conditioned results
    output logic held,
    output logic short_rel,
    output logic long_hit
);
    import smms_pkg::*;

    logic [CNT_W-1:0] deb_q;
    logic [CNT_W-1:0] hold_q;
    logic long_done_q;

    // the level must stay different for a full debounce window before it is taken
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            deb_q <= '0;
            held <= 1'b0;
        end else if (held == button_n) begin
            if (deb_q >= CNT_W'(DEBOUNCE_CYC - 1)) begin
                deb_q <= '0;
                held <= !button_n;
            end else begin
                deb_q <= deb_q + 1'b1;
            end
        end else begin
            deb_q <= '0;
        end
    end

    // hold counter saturates so a stuck button cannot wrap into a short press
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hold_q <= '0;
            long_done_q <= 1'b0;
            long_hit <= 1'b0;
            short_rel <= 1'b0;
        end else begin
            long_hit <= 1'b0;
            short_rel <= 1'b0;
            if (held) begin
                if (hold_q != '1) begin
                    hold_q <= hold_q + 1'b1;
                end
                if (hold_q == CNT_W'(LONG_CYC - 1) && !long_done_q) begin
                    long_hit <= 1'b1;
                    long_done_q <= 1'b1;
                end
            end else begin
                if (hold_q != '0 && hold_q < CNT_W'(LONG_CYC)) begin
                    short_rel <= 1'b1;
                end
                hold_q <= '0;
                long_done_q <= 1'b0;
            end
        end
    end

    AST_LONG_ONCE: assert property (@(posedge clk) disable iff (!reset_n)
        long_hit |=> !long_hit) else $error("long press pulse repeated");
    AST_SHORT_NEEDS_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
        short_rel |-> $past(held, 2)) else $error("short press without hold");
endmodule // smms_button

// [rtl/smms_indicators.sv]
/*
 * indicator drivers: diagnostic leds and per-terminal status leds.
 * assumes terminal levels are synchronous to clk.
 */
module smms_indicators (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // sources
    input wire logic supply_ok,
    input wire logic ext_variant,
    input wire logic ext_present,
    input wire logic ext_activity,
    input wire logic error_any,
    input wire logic setup_state,
    input wire logic link_activity,
    input wire logic [smms_pkg::NUM_IN-1:0] in_terminal,
    input wire logic [smms_pkg::NUM_OUT-1:0] out_terminal,
    // leds
    output logic supply_indicator,
    output logic bus_indicator,
    output logic error_indicator,
    output logic setup_indicator,
    output logic [smms_pkg::NUM_IN-1:0] in_led,
    output logic [smms_pkg::NUM_OUT-1:0] out_led
);
    import smms_pkg::*;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            supply_indicator <= 1'b0;
            bus_indicator <= 1'b0;
            error_indicator <= 1'b0;
            setup_indicator <= 1'b0;
        end else begin
            supply_indicator <= supply_ok;
            bus_indicator <= ext_variant && ext_present && ext_activity;
            error_indicator <= error_any;
            // activity inverts the steady setup state for a cycle
            setup_indicator <= setup_state ^ link_activity;
        end
    end

    // leds follow the pins, never the process image
    // split per kind so each led bit has exactly one process behind it
    for (genvar i = 0; i < NUM_IN + NUM_OUT; i++) begin : g_led
        if (i < NUM_IN) begin : g_in
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    in_led[i] <= 1'b0;
                end else begin
                    in_led[i] <= in_terminal[i];
                end
            end
        end else begin : g_out
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    out_led[i - NUM_IN] <= 1'b0;
                end else begin
                    out_led[i - NUM_IN] <= out_terminal[i - NUM_IN];
                end
            end
        end
    end

    AST_BUS_ONLY_WITH_DEV: assert property (@(posedge clk) disable iff (!reset_n)
        bus_indicator |-> $past(ext_present)) else $error("bus led without device");
    // the first edge after release still shows the reset value, so skip it
    AST_IN_LED_TRACKS: assert property (@(posedge clk) disable iff (!reset_n)
        $past(reset_n) |-> in_led == $past(in_terminal))
        else $error("input led mismatch");
endmodule // smms_indicators

// [rtl/smms_supervisor.sv]
/*
 * safety module mode supervisor: operating mode, configuration acceptance,
 * error clearing, warm restart, memory module presence and the apb registers.
 * assumes all inputs synchronous to clk; the apb master follows the
 * usual setup/access sequence.
 */
// Added by the designer: the APB register port and the placing of the registers.
module smms_supervisor #(
    parameter int DEBOUNCE_CYC = smms_pkg::DEBOUNCE_CYC_DEF,
    parameter int SHORT_CYC = smms_pkg::SHORT_PRESS_CYC_DEF,
    parameter int LONG_CYC = smms_pkg::LONG_PRESS_CYC_DEF
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // board and operator
    input wire logic button_n,
    input wire logic usb_attached,
    input wire logic usb_activity,
    input wire logic stick_present,
    input wire logic stick_has_config,
    input wire logic supply_ok,
    input wire logic ext_variant,
    input wire logic ext_present,
    input wire logic ext_activity,
    input wire logic [smms_pkg::NUM_IN-1:0] in_terminal,
    input wire logic [smms_pkg::NUM_OUT-1:0] out_terminal,
    // outputs and leds
    output logic [smms_pkg::NUM_OUT-1:0] out_enable,
    output logic functions_run,
    output logic std_mode,
    output logic supply_indicator,
    output logic bus_indicator,
    output logic error_indicator,
    output logic setup_indicator,
    output logic [smms_pkg::NUM_IN-1:0] in_led,
    output logic [smms_pkg::NUM_OUT-1:0] out_led
);
    import smms_pkg::*;

    logic held;
    logic short_rel;
    logic long_hit;
    smms_mode_t mode_q;
    logic [31:0] ctrl_q;
    logic [7:0] err_q;
    logic [7:0] err_cause_q;
    logic [3:0] out_req_q;
    logic pending_q;
    logic dl_busy_q;
    logic dl_refused_q;
    logic store_req_q;
    logic swap_q;
    logic stick_err_q;
    logic [7:0] restarts_q;
    logic [4:0] safe_cnt_q;
    logic stick_seen_q;
    logic activity_q;
    logic acc;
    logic wr;
    logic ctl_wr;
    logic dl_start;
    logic dl_done;

    smms_button #(
        .DEBOUNCE_CYC(DEBOUNCE_CYC),
        .SHORT_CYC(SHORT_CYC),
        .LONG_CYC(LONG_CYC)
    ) u_button (
        .clk(clk),
        .reset_n(reset_n),
        .button_n(button_n),
        .held(held),
        .short_rel(short_rel),
        .long_hit(long_hit)
    );

    smms_indicators u_ind (
        .clk(clk),
        .reset_n(reset_n),
        .supply_ok(supply_ok),
        .ext_variant(ext_variant),
        .ext_present(ext_present),
        .ext_activity(ext_activity),
        .error_any(err_q != '0 || stick_err_q),
        .setup_state(!pending_q && mode_q != SMMS_INIT),
        .link_activity(activity_q),
        .in_terminal(in_terminal),
        .out_terminal(out_terminal),
        .supply_indicator(supply_indicator),
        .bus_indicator(bus_indicator),
        .error_indicator(error_indicator),
        .setup_indicator(setup_indicator),
        .in_led(in_led),
        .out_led(out_led)
    );

    // apb: one wait-free access phase, every access answered
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign ctl_wr = wr && paddr == ADDR_CTRL;
    assign dl_start = ctl_wr && pwdata[CTRL_DL_START];
    assign dl_done = ctl_wr && pwdata[CTRL_DL_DONE];

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (psel && !penable) begin
                unique case (paddr)
                    ADDR_CTRL: prdata <= ctrl_q;
                    ADDR_STATUS: prdata <= {8'h00, restarts_q, 7'h00, swap_q, store_req_q,
                        dl_refused_q, pending_q, usb_attached, stick_present, mode_q};
                    ADDR_ERR: prdata <= {24'h00_0000, err_q};
                    ADDR_ERR_CAUSE: prdata <= {24'h00_0000, err_cause_q};
                    ADDR_OUT_REQ: prdata <= {28'h000_0000, out_req_q};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    // control/request registers written by the usb side of the firmware
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= CTRL_RESET;
            err_cause_q <= ERR_RESET;
            out_req_q <= OUT_REQ_RESET;
        end else if (wr) begin
            if (paddr == ADDR_CTRL) begin
                ctrl_q <= pwdata & 32'h0000_000C;
            end
            if (paddr == ADDR_ERR_CAUSE) begin
                err_cause_q <= pwdata[7:0];
            end
            if (paddr == ADDR_OUT_REQ) begin
                out_req_q <= pwdata[3:0];
            end
        end
    end

    // configuration download handshake
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dl_busy_q <= 1'b0;
            dl_refused_q <= 1'b0;
            pending_q <= 1'b0;
            store_req_q <= 1'b0;
        end else begin
            if (dl_start) begin
                dl_refused_q <= !stick_present;
                dl_busy_q <= stick_present;
            end else if (dl_done && dl_busy_q) begin
                dl_busy_q <= 1'b0;
                pending_q <= 1'b1;
                store_req_q <= 1'b1;
            end else if (!stick_present) begin
                dl_busy_q <= 1'b0;
            end
            if (short_rel && pending_q && !dl_busy_q) begin
                pending_q <= 1'b0;
                store_req_q <= 1'b0;
            end
        end
    end

    // errors: hardware set wins over button clear; restart keeps live causes
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            err_q <= ERR_RESET;
        end else begin
            if (mode_q == SMMS_SAFE && safe_cnt_q == 5'd0) begin
                err_q <= err_cause_q;
            end else if (short_rel && !pending_q && !ctrl_q[CTRL_ERR_LONG]) begin
                err_q <= err_cause_q;
            end else if (long_hit && ctrl_q[CTRL_ERR_LONG]) begin
                err_q <= err_cause_q;
            end else begin
                err_q <= err_q | err_cause_q;
            end
        end
    end

    // a missing module is an error unless the swap procedure is running
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stick_err_q <= 1'b0;
            swap_q <= 1'b0;
            stick_seen_q <= 1'b0;
        end else begin
            stick_seen_q <= stick_present;
            if (stick_seen_q && !stick_present) begin
                swap_q <= held;
            end else if (stick_present && !held) begin
                swap_q <= 1'b0;
            end
            if (!stick_present) begin
                stick_err_q <= !(swap_q || (stick_seen_q && held));
            end else if (!swap_q) begin
                stick_err_q <= stick_err_q && mode_q == SMMS_HALT;
            end else begin
                stick_err_q <= 1'b0;
            end
        end
    end

    // operating mode
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= SMMS_INIT;
            safe_cnt_q <= 5'd0;
            restarts_q <= 8'h00;
        end else begin
            if (long_hit) begin
                mode_q <= SMMS_SAFE;
                safe_cnt_q <= 5'(RESTART_SAFE_CYC - 1);
                restarts_q <= restarts_q + 8'h01;
            end else begin
                unique case (mode_q)
                    SMMS_INIT: begin
                        if (!stick_present) mode_q <= SMMS_HALT;
                        else if (usb_attached) mode_q <= SMMS_STD;
                        else if (stick_has_config && ctrl_q[CTRL_RUN_EN])
                            mode_q <= SMMS_RUN;
                    end
                    SMMS_RUN: begin
                        if (!stick_present) mode_q <= held ? SMMS_SWAP : SMMS_HALT;
                        else if (usb_attached) mode_q <= SMMS_STD;
                    end
                    SMMS_STD: begin
                        if (!stick_present) mode_q <= SMMS_HALT;
                        else if (!usb_attached) mode_q <= SMMS_INIT;
                    end
                    SMMS_HALT: begin
                        if (swap_q && stick_present) mode_q <= SMMS_INIT;
                    end
                    SMMS_SWAP: begin
                        if (stick_present && !held) mode_q <= SMMS_INIT;
                    end
                    SMMS_SAFE: begin
                        if (safe_cnt_q == 5'd0) mode_q <= SMMS_INIT;
                        else safe_cnt_q <= safe_cnt_q - 5'd1;
                    end
                    default: mode_q <= SMMS_SAFE;
                endcase
            end
        end
    end

    // outputs only energise in a running mode with a module present
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            out_enable <= '0;
            functions_run <= 1'b0;
            std_mode <= 1'b0;
            activity_q <= 1'b0;
        end else begin
            functions_run <= (mode_q == SMMS_RUN || mode_q == SMMS_STD) && stick_present;
            std_mode <= mode_q == SMMS_STD;
            activity_q <= usb_activity || dl_busy_q;
            if ((mode_q == SMMS_RUN || mode_q == SMMS_STD) && stick_present && !pending_q)
                out_enable <= out_req_q;
            else
                out_enable <= '0;
        end
    end

    sequence s_restart;
        long_hit ##1 mode_q == SMMS_SAFE;
    endsequence

    AST_USB_STD: assert property (@(posedge clk) disable iff (!reset_n)
        mode_q == SMMS_STD |=> std_mode) else $error("std flag missing");
    AST_RESTART_SAFE: assert property (@(posedge clk) disable iff (!reset_n)
        s_restart |=> out_enable == '0) else $error("outputs live in restart");
    AST_RESTART_TO_INIT: assert property (@(posedge clk) disable iff (!reset_n)
        s_restart |-> ##[15:17] mode_q == SMMS_INIT) else $error("restart too long");
    AST_NO_STICK_OFF: assert property (@(posedge clk) disable iff (!reset_n)
        !stick_present |=> out_enable == '0) else $error("outputs with no module");
    AST_REFUSE_DL: assert property (@(posedge clk) disable iff (!reset_n)
        dl_start && !stick_present |=> dl_refused_q && !dl_busy_q)
        else $error("download not refused");
    AST_ACCEPT: assert property (@(posedge clk) disable iff (!reset_n)
        short_rel && pending_q && !dl_busy_q && !dl_done |=> !pending_q)
        else $error("config not accepted");
    AST_STORE: assert property (@(posedge clk) disable iff (!reset_n)
        dl_done && dl_busy_q && !dl_start |=> store_req_q) else $error("no store");
    AST_SWAP_NO_ERR: assert property (@(posedge clk) disable iff (!reset_n)
        swap_q && !stick_present |=> !stick_err_q) else $error("swap shows error");
    AST_STARTUP_HALT: assert property (@(posedge clk) disable iff (!reset_n)
        mode_q == SMMS_INIT && !stick_present && !long_hit |=> mode_q == SMMS_HALT)
        else $error("startup without module ran");
endmodule // smms_supervisor

// [tb/smms_host_model.sv]
/* far side: configuration pc link and operator at the button and stick.
   assumes its tasks are called just after a rising edge of clk. */
module smms_host_model (
    // clock
    input wire logic clk,
    // operator and link
    output logic button_n,
    output logic usb_attached,
    output logic usb_activity,
    output logic stick_present,
    output logic stick_has_config
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        button_n = 1'b1;
        usb_attached = 1'b0;
        usb_activity = 1'b0;
        stick_present = 1'b0;
        stick_has_config = 1'b1;
    end
    // traffic only while a host is attached; a detached link stays quiet
    always @(posedge clk) begin
        usb_activity <= usb_attached & ~usb_activity;
    end
    task automatic hold(input logic b);
        button_n <= ~b;
    endtask
    task automatic plug(input logic s);
        stick_present <= s;
    endtask
    task automatic link(input logic u);
        usb_attached <= u;
    endtask
    task automatic cfg(input logic c);
        stick_has_config <= c;
    endtask
    // button stays held across removal and insertion
    task automatic swap_out();
        hold(1'b1);
        repeat (6) @(posedge clk);
        plug(1'b0);
    endtask
    task automatic swap_in();
        plug(1'b1);
        repeat (2) @(posedge clk);
        hold(1'b0);
    endtask
endmodule // smms_host_model

// [tb/testbench.sv]
/* self-checking bench for the mode supervisor over apb.
   assumes the host model drives button, usb and stick lines. */
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import smms_pkg::*;
    localparam int DB = 4;
    localparam int LG = 64;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic supply_ok = 1'b1, ext_variant = 1'b1, ext_present = 1'b0, ext_activity = 1'b1;
    logic [NUM_IN-1:0] in_terminal = 20'h0_0000;
    logic [NUM_OUT-1:0] out_terminal = 4'h0;
    logic [31:0] prdata, rdata;
    logic pready, pslverr, rerr, button_n, usb_attached, usb_activity, stick_present;
    logic stick_has_config, functions_run, std_mode, supply_indicator, bus_indicator;
    logic error_indicator, setup_indicator;
    logic [NUM_IN-1:0] in_led;
    logic [NUM_OUT-1:0] out_led, out_enable;
    int error_cnt = 0;
    int samples_checked = 0;
    smms_supervisor #(.DEBOUNCE_CYC(DB), .SHORT_CYC(20), .LONG_CYC(LG)) uut (
        .clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .button_n, .usb_attached, .usb_activity, .stick_present,
        .stick_has_config, .supply_ok, .ext_variant, .ext_present, .ext_activity,
        .in_terminal, .out_terminal, .out_enable, .functions_run, .std_mode,
        .supply_indicator, .bus_indicator, .error_indicator, .setup_indicator,
        .in_led, .out_led);
    smms_host_model host (.clk, .button_n, .usb_attached, .usb_activity, .stick_present,
        .stick_has_config);
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one edge passes after release so a following call never reassigns psel at once
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdc(input string w, input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        check(w, e, rdata & m);
    endtask
    task automatic press(input int n);
        host.hold(1'b1);
        tick(n);
        host.hold(1'b0);
        tick(8);
    endtask
    task automatic rst(input logic s);
        reset_n <= 1'b0;
        host.plug(s);
        tick(3);
        reset_n <= 1'b1;
        tick(1);
        bus(1'b1, ADDR_CTRL, 32'h0000_0008);
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        tick(5000);
        error_cnt++;
        $display("Error watchdog expected end seen timeout");
        stop_test();
    end
    initial begin
        rst(1'b0);
        tick(10);
        check("err led", 1, error_indicator);
        check("out en", 0, out_enable);
        check("run", 0, functions_run);
        $display("test no stick done");
        rst(1'b1);
        bus(1'b1, ADDR_OUT_REQ, 32'h0000_000F);
        in_terminal <= 20'hA_5A5A;
        out_terminal <= 4'h9;
        tick(10);
        check("supply led", 1, supply_indicator);
        check("setup led", 1, setup_indicator);
        check("bus led", 0, bus_indicator);
        check("in led", 20'hA_5A5A, in_led);
        check("out led", 4'h9, out_led);
        check("out en", 4'hF, out_enable);
        supply_ok <= 1'b0;
        tick(2);
        check("supply led", 0, supply_indicator);
        supply_ok <= 1'b1;
        ext_present <= 1'b1;
        bus(1'b0, 8'h14, 32'h0000_0000);
        check("slverr", 1, rerr);
        check("unmapped", 0, rdata);
        rdc("ctrl", ADDR_CTRL, 32'hFFFF_FFFF, 32'h0000_0008);
        check("bus led", 1, bus_indicator);
        ext_activity <= 1'b0;
        tick(2);
        check("bus idle", 0, bus_indicator);
        ext_activity <= 1'b1;
        ext_variant <= 1'b0;
        tick(2);
        check("bus variant", 0, bus_indicator);
        ext_variant <= 1'b1;
        host.link(1'b1);
        tick(6);
        check("std", 1, std_mode);
        rdc("mode", ADDR_STATUS, 32'h0000_0007, SMMS_STD);
        host.link(1'b0);
        tick(6);
        check("std", 0, std_mode);
        $display("test basic done");
        host.swap_out();
        tick(4);
        check("out en", 0, out_enable);
        check("err led", 0, error_indicator);
        rdc("swap", ADDR_STATUS, 32'h0000_0107, 32'h0000_0106);
        host.swap_in();
        tick(10);
        check("err led", 0, error_indicator);
        $display("test swap done");
        host.link(1'b1);
        bus(1'b1, ADDR_CTRL, 32'h0000_0009);
        bus(1'b1, ADDR_CTRL, 32'h0000_000A);
        rdc("pending", ADDR_STATUS, 32'h0000_00A0, 32'h0000_00A0);
        check("out en", 0, out_enable);
        press(10);
        rdc("accepted", ADDR_STATUS, 32'h0000_0020, 32'h0000_0000);
        host.link(1'b0);
        $display("test download done");
        bus(1'b1, ADDR_ERR_CAUSE, 32'h0000_0004);
        bus(1'b1, ADDR_CTRL, 32'h0000_000C);
        bus(1'b1, ADDR_ERR_CAUSE, 32'h0000_0000);
        check("err led", 1, error_indicator);
        press(10);
        rdc("err kept", ADDR_ERR, 32'h0000_00FF, 32'h0000_0004);
        bus(1'b1, ADDR_CTRL, 32'h0000_0008);
        press(10);
        rdc("err clr", ADDR_ERR, 32'h0000_00FF, 32'h0000_0000);
        $display("test errors done");
        host.plug(1'b0);
        tick(4);
        check("out en", 0, out_enable);
        check("run", 0, functions_run);
        check("err led", 1, error_indicator);
        bus(1'b1, ADDR_CTRL, 32'h0000_0009);
        rdc("refused", ADDR_STATUS, 32'h0000_0040, 32'h0000_0040);
        $display("test removal done");
        host.cfg(1'b0);
        rst(1'b1);
        rdc("no config", ADDR_STATUS, 32'h0000_0007, SMMS_INIT);
        check("setup led", 0, setup_indicator);
        host.cfg(1'b1);
        bus(1'b1, ADDR_OUT_REQ, 32'h0000_000F);
        bus(1'b1, ADDR_ERR_CAUSE, 32'h0000_0003);
        bus(1'b1, ADDR_ERR_CAUSE, 32'h0000_0001);
        rdc("latched", ADDR_ERR, 32'h0000_00FF, 32'h0000_0003);
        check("out en", 4'hF, out_enable);
        host.hold(1'b1);
        tick(DB + LG + 8);
        check("out en", 0, out_enable);
        check("run", 0, functions_run);
        host.hold(1'b0);
        tick(40);
        check("out en", 4'hF, out_enable);
        rdc("err live", ADDR_ERR, 32'h0000_00FF, 32'h0000_0001);
        rdc("restarts", ADDR_STATUS, 32'h00FF_0000, 32'h0001_0000);
        $display("test restart done");
        stop_test();
    end
endmodule // testbench
